// File: src/ubm_uart.sv
// serial port core: baud timers, transmitter, receiver and control register
`timescale 1ns/100ps
module ubm_uart (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic baud_timer_run,
    input wire logic [2:0] baud_clk_sel,
    input wire logic [7:0] baud_reload_value,
    input wire logic ext_osc_clk,
    input wire logic baud_timer_ext_input,
    input wire logic serial_irq_enable,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic serial_irq
);
    import ubm_pkg::*;

    typedef enum logic [4:0] {
        UBM_IDLE = 5'b00001,
        UBM_START = 5'b00010,
        UBM_DATA = 5'b00100,
        UBM_NINTH = 5'b01000,
        UBM_STOP = 5'b10000
    } ubm_state_t;

    // ***************************************************
    // pin synchronisers
    // ***************************************************
    logic [1:0] rx_sync;
    logic [1:0] ext_sync;
    logic [1:0] pin_sync;
    logic rx_prev;
    logic ext_prev;
    logic pin_prev;
    // first stage is read only by the second stage
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_sync <= 2'h3;
            ext_sync <= 2'h0;
            pin_sync <= 2'h0;
            rx_prev <= 1'b1;
            ext_prev <= 1'b0;
            pin_prev <= 1'b0;
        end else begin
            rx_sync <= {rx_sync[0], serial_in_pin};
            ext_sync <= {ext_sync[0], ext_osc_clk};
            pin_sync <= {pin_sync[0], baud_timer_ext_input};
            rx_prev <= rx_sync[1];
            ext_prev <= ext_sync[1];
            pin_prev <= pin_sync[1];
        end
    end

    // ***************************************************
    // baud timer clock selection
    // ***************************************************
    logic [5:0] pre_cnt;
    logic [2:0] ext_cnt;
    wire ext_rise = ext_sync[1] & ~ext_prev;
    wire pin_fall = ~pin_sync[1] & pin_prev;
    wire tick4 = (pre_cnt[1:0] == 2'h3);
    wire tick12 = (pre_cnt == UBM_PRE_12A) | (pre_cnt == UBM_PRE_12B) |
                  (pre_cnt == UBM_PRE_12C) | (pre_cnt == UBM_PRE_LAST);
    wire tick48 = (pre_cnt == UBM_PRE_LAST);
    wire tick_ext = ext_rise & (ext_cnt == UBM_EXT_LAST);
    logic src_tick;
    always_comb begin
        case (baud_clk_sel)
            UBM_SRC_SYS: src_tick = 1'b1;
            UBM_SRC_DIV4: src_tick = tick4;
            UBM_SRC_DIV12: src_tick = tick12;
            UBM_SRC_DIV48: src_tick = tick48;
            UBM_SRC_EXT8: src_tick = tick_ext;
            UBM_SRC_PIN: src_tick = pin_fall;
            default: src_tick = 1'b0;
        endcase
    end
    wire tmr_tick = src_tick & baud_timer_run;
    // prescaler free-runs so the divided sources keep their phase
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_cnt <= 6'h0;
            ext_cnt <= 3'h0;
        end else begin
            pre_cnt <= (pre_cnt == UBM_PRE_LAST) ? 6'h0 : pre_cnt + 6'h1;
            if (ext_rise)
                ext_cnt <= ext_cnt + 3'h1;
        end
    end

    // ***************************************************
    // transmit and hidden receive timers
    // ***************************************************
    logic [7:0] baud_timer_low_byte;
    logic [7:0] rx_timer;
    logic tx_half;
    logic rx_half;
    logic start_det;
    wire tx_ovf = tmr_tick & (baud_timer_low_byte == UBM_TMR_TOP);
    wire rx_ovf = tmr_tick & (rx_timer == UBM_TMR_TOP) & ~start_det;
    // every second overflow makes one bit time
    wire tx_bit_tick = tx_ovf & tx_half;
    wire rx_sample = rx_ovf & ~rx_half;
    // auto-reload counter, reload at top gives 256 minus reload per overflow
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            baud_timer_low_byte <= 8'h0;
            tx_half <= 1'b0;
        end else if (tmr_tick) begin
            baud_timer_low_byte <= tx_ovf ? baud_reload_value : baud_timer_low_byte + 8'h1;
            tx_half <= tx_half ^ tx_ovf;
        end
    end
    // copy timer; a start reloads it so sampling starts half a bit later
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_timer <= 8'h0;
            rx_half <= 1'b0;
        end else if (start_det) begin
            rx_timer <= baud_reload_value;
            rx_half <= 1'b0;
        end else if (tmr_tick) begin
            rx_timer <= rx_ovf ? baud_reload_value : rx_timer + 8'h1;
            rx_half <= rx_half ^ rx_ovf;
        end
    end

    // ***************************************************
    // control register
    // ***************************************************
    logic frame_format_select;
    logic multiproc_enable;
    logic receive_enable_bit;
    logic ninth_tx_bit;
    logic ninth_rx_bit;
    logic tx_done_flag;
    logic rx_done_flag;
    logic tx_set;
    logic rx_load;
    logic rx_ninth_val;
    wire ctrl_wr = sfr_wr & (sfr_addr == UBM_ADDR_CTRL);
    wire data_wr = sfr_wr & (sfr_addr == UBM_ADDR_DATA);
    // bit 6 has no storage and always reads one
    wire [7:0] ctrl_view = {frame_format_select, 1'b1, multiproc_enable, receive_enable_bit,
                            ninth_tx_bit, ninth_rx_bit, tx_done_flag, rx_done_flag};
    // software can only clear flags, and a hardware set beats the clear
    wire next_tx_flag = tx_set | (tx_done_flag & ~(ctrl_wr & ~sfr_wdata[UBM_BIT_TXF]));
    wire next_rx_flag = rx_load | (rx_done_flag & ~(ctrl_wr & ~sfr_wdata[UBM_BIT_RXF]));
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            frame_format_select <= UBM_CTRL_RESET[UBM_BIT_FORMAT];
            multiproc_enable <= UBM_CTRL_RESET[UBM_BIT_MPE];
            receive_enable_bit <= UBM_CTRL_RESET[UBM_BIT_REN];
            ninth_tx_bit <= UBM_CTRL_RESET[UBM_BIT_TB9];
            ninth_rx_bit <= UBM_CTRL_RESET[UBM_BIT_RB9];
            tx_done_flag <= UBM_CTRL_RESET[UBM_BIT_TXF];
            rx_done_flag <= UBM_CTRL_RESET[UBM_BIT_RXF];
        end else begin
            if (ctrl_wr) begin
                frame_format_select <= sfr_wdata[UBM_BIT_FORMAT];
                multiproc_enable <= sfr_wdata[UBM_BIT_MPE];
                receive_enable_bit <= sfr_wdata[UBM_BIT_REN];
                ninth_tx_bit <= sfr_wdata[UBM_BIT_TB9];
            end
            // hardware load of the ninth field wins over a write
            if (rx_load)
                ninth_rx_bit <= rx_ninth_val;
            else if (ctrl_wr)
                ninth_rx_bit <= sfr_wdata[UBM_BIT_RB9];
            tx_done_flag <= next_tx_flag;
            rx_done_flag <= next_rx_flag;
        end
    end
    // interrupt follows either flag while enabled
    assign serial_irq = (tx_done_flag | rx_done_flag) & serial_irq_enable;

    // ***************************************************
    // transmitter
    // ***************************************************
    ubm_state_t tx_state;
    logic [7:0] tx_shift;
    logic [3:0] tx_cnt;
    logic tx_pend;
    // frame sequencing, one step per bit time; the data state holds for all eight data bits
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_state <= UBM_IDLE;
            tx_shift <= 8'h0;
            tx_cnt <= 4'h0;
            tx_pend <= 1'b0;
            serial_out_pin <= 1'b1;
        end else begin
            if (data_wr) begin
                tx_shift <= sfr_wdata;
                tx_pend <= 1'b1;
            end
            if (tx_bit_tick) begin
                case (tx_state)
                    UBM_IDLE: begin
                        if (tx_pend & ~data_wr) begin
                            tx_pend <= 1'b0;
                            tx_state <= UBM_START;
                            serial_out_pin <= 1'b0;
                        end
                    end
                    UBM_START: begin
                        tx_state <= UBM_DATA;
                        tx_cnt <= 4'h0;
                        serial_out_pin <= tx_shift[0];
                    end
                    UBM_DATA: begin
                        tx_cnt <= tx_cnt + 4'h1;
                        if (tx_cnt != UBM_DATA_LAST) begin
                            serial_out_pin <= tx_shift[tx_cnt[2:0] + 3'h1];
                        end else if (frame_format_select) begin
                            tx_state <= UBM_NINTH;
                            serial_out_pin <= ninth_tx_bit;
                        end else begin
                            tx_state <= UBM_STOP;
                            serial_out_pin <= 1'b1;
                        end
                    end
                    UBM_NINTH: begin
                        tx_state <= UBM_STOP;
                        serial_out_pin <= 1'b1;
                    end
                    UBM_STOP: tx_state <= UBM_IDLE;
                    default: tx_state <= UBM_IDLE;
                endcase
            end
        end
    end
    // flag rises as the stop bit begins
    assign tx_set = tx_bit_tick & (((tx_state == UBM_DATA) & (tx_cnt == UBM_DATA_LAST) &
                    ~frame_format_select) | (tx_state == UBM_NINTH));

    // ***************************************************
    // receiver
    // ***************************************************
    ubm_state_t rx_state;
    logic [7:0] rx_shift;
    logic [7:0] rx_latch;
    logic [3:0] rx_cnt;
    logic rx_ninth;
    // falling edge on an idle, enabled line
    assign start_det = (rx_state == UBM_IDLE) & receive_enable_bit & rx_prev & ~rx_sync[1];
    wire at_stop = rx_sample & (rx_state == UBM_STOP);
    // while multiproc_enable is set, the ninth sample or stop gates the load
    assign rx_ninth_val = frame_format_select ? rx_ninth : rx_sync[1];
    // load only while the flag is clear, so an overrun keeps the first byte
    assign rx_load = at_stop & ~rx_done_flag & (~multiproc_enable | rx_ninth_val);
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_state <= UBM_IDLE;
            rx_shift <= 8'h0;
            rx_cnt <= 4'h0;
            rx_ninth <= 1'b0;
        end else if (~receive_enable_bit) begin
            rx_state <= UBM_IDLE;
        end else if (start_det) begin
            rx_state <= UBM_START;
        end else if (rx_sample) begin
            case (rx_state)
                UBM_START: begin
                    // a glitch that is high again mid start bit is dropped
                    rx_state <= rx_sync[1] ? UBM_IDLE : UBM_DATA;
                    rx_cnt <= 4'h0;
                end
                UBM_DATA: begin
                    rx_shift <= {rx_sync[1], rx_shift[7:1]};
                    rx_cnt <= rx_cnt + 4'h1;
                    if (rx_cnt == UBM_DATA_LAST)
                        rx_state <= frame_format_select ? UBM_NINTH : UBM_STOP;
                end
                UBM_NINTH: begin
                    rx_ninth <= rx_sync[1];
                    rx_state <= UBM_STOP;
                end
                UBM_STOP: rx_state <= UBM_IDLE;
                default: rx_state <= UBM_IDLE;
            endcase
        end
    end
    // latch the byte only on a qualified load
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            rx_latch <= 8'h0;
        else if (rx_load)
            rx_latch <= rx_shift;
    end

    // ***************************************************
    // register read port
    // ***************************************************
    // data reads see the receive latch, transmit data is write-only
    wire [7:0] rd_mux = (sfr_addr == UBM_ADDR_CTRL) ? ctrl_view :
                        (sfr_addr == UBM_ADDR_DATA) ? rx_latch : 8'h0;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst)
            sfr_rdata <= 8'h0;
        else if (sfr_rd)
            sfr_rdata <= rd_mux;
    end

    // ***************************************************
    // assertions
    // ***************************************************
    a_bit6_one: assert property (@(posedge ref_clk) disable iff (sys_rst)
        sfr_rd && sfr_addr == UBM_ADDR_CTRL |=> sfr_rdata[UBM_BIT_ONE]) else $error("bit 6 read low");
    a_tx_flag_stop: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tx_state == UBM_STOP && $past(tx_state) != UBM_STOP |-> tx_done_flag) else $error("tx flag late");
    a_flag_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tx_done_flag && !ctrl_wr |=> tx_done_flag) else $error("tx flag lost");
    a_rx_no_overrun: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rx_done_flag && !ctrl_wr |=> $stable(rx_latch)) else $error("latch overwritten");
    a_mpe_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
        rx_load && frame_format_select && multiproc_enable |=> ninth_rx_bit && rx_done_flag)
        else $error("address gate broken");
    a_rx_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !receive_enable_bit |=> rx_state == UBM_IDLE) else $error("receiver active while off");
    a_start_reload: assert property (@(posedge ref_clk) disable iff (sys_rst)
        start_det |=> rx_timer == $past(baud_reload_value) && !rx_half) else $error("no reload on start");
    a_irq_flags: assert property (@(posedge ref_clk) disable iff (sys_rst)
        serial_irq_enable && (tx_done_flag || rx_done_flag) |-> serial_irq) else $error("irq missing");
    a_tx_start_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tx_state == UBM_START |-> !serial_out_pin) else $error("start bit not low");
    a_tx_ninth: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tx_state == UBM_NINTH && $past(tx_state) != UBM_NINTH |-> serial_out_pin == $past(ninth_tx_bit))
        else $error("ninth bit wrong");
    a_bit_divide: assert property (@(posedge ref_clk) disable iff (sys_rst)
        tx_ovf |=> tx_half != $past(tx_half)) else $error("tx divide broken");
endmodule : ubm_uart

// File: src/ubm_pkg.sv
// package of constants for the serial port with multiprocessor support
package ubm_pkg;
    // ***************************************************
    // register map
    // ***************************************************
    localparam logic [7:0] UBM_ADDR_CTRL = 8'h98;
    localparam logic [7:0] UBM_ADDR_DATA = 8'h99;
    localparam logic [7:0] UBM_CTRL_RESET = 8'h40;
    // ***************************************************
    // control field positions
    // ***************************************************
    localparam int UBM_BIT_FORMAT = 7;
    localparam int UBM_BIT_ONE = 6;
    localparam int UBM_BIT_MPE = 5;
    localparam int UBM_BIT_REN = 4;
    localparam int UBM_BIT_TB9 = 3;
    localparam int UBM_BIT_RB9 = 2;
    localparam int UBM_BIT_TXF = 1;
    localparam int UBM_BIT_RXF = 0;
    // ***************************************************
    // baud timer clock sources and prescaler
    // ***************************************************
    localparam logic [2:0] UBM_SRC_SYS = 3'h0;
    localparam logic [2:0] UBM_SRC_DIV4 = 3'h1;
    localparam logic [2:0] UBM_SRC_DIV12 = 3'h2;
    localparam logic [2:0] UBM_SRC_DIV48 = 3'h3;
    localparam logic [2:0] UBM_SRC_EXT8 = 3'h4;
    localparam logic [2:0] UBM_SRC_PIN = 3'h5;
    localparam logic [5:0] UBM_PRE_LAST = 6'h2f;
    localparam logic [5:0] UBM_PRE_12A = 6'h0b;
    localparam logic [5:0] UBM_PRE_12B = 6'h17;
    localparam logic [5:0] UBM_PRE_12C = 6'h23;
    localparam logic [2:0] UBM_EXT_LAST = 3'h7;
    localparam logic [7:0] UBM_TMR_TOP = 8'hff;
    localparam logic [3:0] UBM_DATA_LAST = 4'h7;
endpackage : ubm_pkg

// File: verif/ubm_remote_model.sv
// remote serial device model: frame sender and frame capture
`timescale 1ns/100ps
module ubm_remote_model (
    input wire logic ref_clk,
    input wire logic serial_out_pin,
    output logic serial_in_pin
);
    // the line idles high between frames
    initial begin
        serial_in_pin = 1'b1;
    end
    task automatic send(input logic [7:0] d, input logic nine, input logic stop,
                        input logic mode9, input int bc);
        logic [10:0] f;
        int n;
        f = mode9 ? {stop, nine, d, 1'b0} : {1'b0, stop, d, 1'b0};
        n = mode9 ? 11 : 10;
        for (int i = 0; i < n; i++) begin
            serial_in_pin <= f[i];
            repeat (bc) @(posedge ref_clk);
        end
        serial_in_pin <= 1'b1;
        // one idle cycle so a following frame never writes the line in the same step
        @(posedge ref_clk);
    endtask : send
    // mid-cell sampling
    // negedge sampling keeps clear of the pin's own update edge
    task automatic capture(input int n, input int bc, output logic [10:0] f, output logic ok);
        int w;
        f = '0;
        w = 0;
        // the first frame after reset waits for a full 256-tick timer run
        while (serial_out_pin !== 1'b0 && w < 72 * bc + 64) begin
            @(negedge ref_clk);
            w++;
        end
        ok = (serial_out_pin === 1'b0);
        repeat (bc / 2) @(negedge ref_clk);
        for (int i = 0; i < n; i++) begin
            f[i] = serial_out_pin;
            repeat (bc) @(negedge ref_clk);
        end
    endtask : capture
endmodule : ubm_remote_model

// File: verif/ubm_uart_tb_top.sv
// testbench for the serial port: registers, frames both ways, clock sources
`timescale 1ns/100ps
module ubm_uart_tb_top;
    import ubm_pkg::*;
    typedef struct packed {
        logic mode9, mce, ren, nine, stop;
        logic [7:0] data;
        logic load;
    } ubm_row_t;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic baud_timer_run = 1'b0;
    logic [2:0] baud_clk_sel = 3'h0;
    logic [7:0] baud_reload_value = 8'hfe;
    logic ext_osc_clk = 1'b0;
    logic baud_timer_ext_input = 1'b0;
    logic serial_irq_enable = 1'b0;
    logic serial_in_pin;
    logic serial_out_pin;
    logic serial_irq;
    logic [3:0] div_cnt = 4'h0;
    ubm_row_t row;
    logic fb;
    logic ok;
    logic [10:0] got;
    logic [7:0] rd;
    logic [7:0] lat = 8'h00;
    logic [7:0] tbyte;
    int errors = 0;
    int n_tests = 0;
    // clocks per bit for each timer source with reload 0xfe
    int bcs [6] = '{4, 16, 48, 192, 128, 16};
    // receive cases: one frame per row, both formats, with and without the multiprocessor gate, and one with the receiver off
    ubm_row_t rows [7] = '{
        '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'ha5, 1'b1},
        '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h3c, 1'b0},
        '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h5a, 1'b1},
        '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'h81, 1'b1},
        '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h42, 1'b0},
        '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'hc3, 1'b1},
        '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h99, 1'b0}
    };
    ubm_uart ubm_uart_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .baud_timer_run(baud_timer_run),
        .baud_clk_sel(baud_clk_sel), .baud_reload_value(baud_reload_value), .ext_osc_clk(ext_osc_clk),
        .baud_timer_ext_input(baud_timer_ext_input), .serial_irq_enable(serial_irq_enable),
        .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .serial_irq(serial_irq));
    ubm_remote_model remote_i (.ref_clk(ref_clk), .serial_out_pin(serial_out_pin),
        .serial_in_pin(serial_in_pin));
    // 25 ns system clock
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    // slow pin clocks for the external sources, far below the synchroniser limit
    always @(posedge ref_clk) begin
        div_cnt <= div_cnt + 4'h1;
        ext_osc_clk <= div_cnt[1];
        baud_timer_ext_input <= div_cnt[1];
    end
    task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : print_verdict
    // a frame that never starts ends the run
    task automatic frame_check(input logic [10:0] exp);
        if (ok !== 1'b1) begin
            errors++;
            print_verdict();
        end
        check("tx frame", got, exp);
    endtask : frame_check
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge ref_clk);
        sfr_rd <= 1'b0;
        @(negedge ref_clk);
        d = sfr_rdata;
    endtask : reg_rd
    // main sequence: reset, receive table, overrun, timer sources
    initial begin
        @(negedge ref_clk);
        check("idle line", serial_out_pin, 1'b1);
        check("rdata in reset", sfr_rdata, 8'h00);
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        baud_timer_run <= 1'b1;
        reg_rd(UBM_ADDR_CTRL, rd);
        check("ctrl reset", rd, UBM_CTRL_RESET);
        reg_rd(UBM_ADDR_DATA, rd);
        check("latch reset", rd, 8'h00);
        reg_rd(8'h9a, rd);
        check("unmapped", rd, 8'h00);
        reg_wr(UBM_ADDR_CTRL, 8'hff);
        reg_rd(UBM_ADDR_CTRL, rd);
        check("ctrl ones", rd, 8'hfc);
        reg_wr(UBM_ADDR_CTRL, 8'h00);
        reg_rd(UBM_ADDR_CTRL, rd);
        check("ctrl zeros", rd, 8'h40);
        for (int r = 0; r < 7; r++) begin
            row = rows[r];
            fb = row.mode9 ? row.nine : row.stop;
            // preset ninth field opposite to the frame so a stray load shows
            reg_wr(UBM_ADDR_CTRL, {row.mode9, 1'b0, row.mce, row.ren, row.nine, ~fb, 2'b00});
            serial_irq_enable <= r[0];
            @(negedge ref_clk);
            check("irq cleared", serial_irq, 1'b0);
            fork
                remote_i.send(row.data, row.nine, row.stop, row.mode9, 4);
                remote_i.capture(row.mode9 ? 11 : 10, 4, got, ok);
                reg_wr(UBM_ADDR_DATA, ~row.data);
            join
            frame_check(row.mode9 ? {1'b1, row.nine, ~row.data, 1'b0} : {2'b01, ~row.data, 1'b0});
            repeat (4) @(posedge ref_clk);
            if (row.load) begin
                lat = row.data;
            end
            reg_rd(UBM_ADDR_CTRL, rd);
            check("ctrl", rd, {row.mode9, 1'b1, row.mce, row.ren, row.nine, row.load ? fb : ~fb, 1'b1, row.load});
            reg_rd(UBM_ADDR_DATA, rd);
            check("latch", rd, lat);
            check("irq", serial_irq, r[0]);
        end
        reg_wr(UBM_ADDR_CTRL, 8'h10);
        remote_i.send(8'h11, 1'b0, 1'b1, 1'b0, 4);
        remote_i.send(8'h22, 1'b0, 1'b1, 1'b0, 4);
        repeat (4) @(posedge ref_clk);
        reg_rd(UBM_ADDR_DATA, rd);
        check("overrun latch", rd, 8'h11);
        reg_rd(UBM_ADDR_CTRL, rd);
        check("overrun ctrl", rd, 8'h55);
        for (int s = 0; s < 6; s++) begin
            @(posedge ref_clk);
            baud_clk_sel <= s[2:0];
            tbyte = 8'h30 + s[7:0];
            repeat (2) @(posedge ref_clk);
            fork
                remote_i.capture(10, bcs[s], got, ok);
                reg_wr(UBM_ADDR_DATA, tbyte);
            join
            frame_check({2'b01, tbyte, 1'b0});
        end
        print_verdict();
    end
    // cut a hang short; the full run needs far fewer cycles
    initial begin
        repeat (100000) @(posedge ref_clk);
        errors++;
        print_verdict();
    end
endmodule : ubm_uart_tb_top
